// ===== test/apsp_chk.sv
// Concurrent checks on the protection sequencer pins
`timescale 1ns/1ps
module apsp_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Causes
    input wire logic [3:0] gate_drive_supply_ok,
    input wire logic temp_above_125,
    input wire logic temp_above_155,
    input wire logic overcurrent_det,
    input wire logic reset_pin_n,
    // Effects
    input wire logic bridge_enable,
    input wire logic weak_pulldown_en,
    input wire logic short_test_gnd,
    input wire logic short_test_supply,
    input wire logic shutdown_n_o,
    input wire logic shutdown_n_oe,
    input wire logic thermal_warning_high_oe,
    input wire logic ready
);
    default clocking dck @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    sequence s_supply_step;
        $rose(short_test_supply);
    endsequence
    property p_step_order;
        s_supply_step |-> $past(short_test_gnd);
    endproperty
    // Repeat counts cover two sync flops plus the state edge
    chk_od_low: assert property (!shutdown_n_o)
        else $error("shutdown pin driven high");
    chk_step_excl: assert property (!(short_test_gnd && short_test_supply))
        else $error("both short steps active");
    chk_step_order: assert property (p_step_order)
        else $error("supply step without ground step");
    chk_check_sd: assert property (short_test_gnd || short_test_supply |-> shutdown_n_oe && !bridge_enable)
        else $error("shutdown released during check");
    chk_uv_off: assert property ((gate_drive_supply_ok != 4'hf && reset_pin_n)[*5] |-> !bridge_enable && shutdown_n_oe)
        else $error("bridges on under undervoltage");
    chk_ote_off: assert property ((temp_above_155 && reset_pin_n)[*5] |-> !bridge_enable && shutdown_n_oe)
        else $error("bridges on above shutdown temperature");
    chk_rst_off: assert property ((!reset_pin_n)[*4] |-> !bridge_enable)
        else $error("bridges on while reset low");
    chk_pd_sd: assert property (weak_pulldown_en |-> !shutdown_n_oe && !bridge_enable)
        else $error("pulldown with shutdown low or bridges on");
    chk_warn_hi: assert property (temp_above_125[*4] |-> thermal_warning_high_oe)
        else $error("high warning missing");
    chk_oc_ready: assert property (overcurrent_det[*4] |-> !ready)
        else $error("ready high during overcurrent");
    chk_ready_run: assert property (ready |-> bridge_enable)
        else $error("ready without switching");
endmodule
////////////////////////////////////////
bind apsp_ctrl apsp_chk u_chk (.clk_sys, .rst_n, .gate_drive_supply_ok, .temp_above_125, .temp_above_155,
    .overcurrent_det, .reset_pin_n, .bridge_enable, .weak_pulldown_en, .short_test_gnd, .short_test_supply,
    .shutdown_n_o, .shutdown_n_oe, .thermal_warning_high_oe, .ready);

// ===== test/apsp_host_mdl.sv
// Controller model: drives the reset pin and keeps the shutdown gap
`timescale 1ns/1ps
module apsp_host_mdl #(
    parameter int GAP = 40
) (
    // Clock
    input wire logic clk_sys,
    // Bench request and status pin level
    input wire logic want_reset,
    input wire logic shutdown_n,
    output logic reset_pin_n
);
    logic sd_q = 1'b1;
    int gap_cnt = 0;
    initial reset_pin_n = 1'b1;
    always @(posedge clk_sys) begin
        sd_q <= shutdown_n;
        // Every fall of shutdown restarts the wait before reset may rise
        if (sd_q && !shutdown_n)
            gap_cnt <= 0;
        else if (gap_cnt < GAP)
            gap_cnt <= gap_cnt + 1;
        // A reset pulse, or a loss of the logic supply, clears latched faults
        if (want_reset)
            reset_pin_n <= 1'b0;
        else if (gap_cnt >= GAP)
            reset_pin_n <= 1'b1;
    end
endmodule

// ===== test/tb_apsp_ctrl.sv
// Self-checking bench for the power stage protection sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_apsp_ctrl;
    localparam int GAP = 40;
    logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, probe = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, gate_drive_supply_ok = 4'hf;
    logic logic_supply_ok = 1'b0, want_reset = 1'b0, overload_det = 1'b0, overcurrent_det = 1'b0;
    logic short_gnd_det = 1'b0, short_supply_det = 1'b0;
    logic temp_above_100 = 1'b0, temp_above_125 = 1'b0, temp_above_155 = 1'b0;
    logic [31:0] avs_writedata = 32'h0, seed = 32'h8eb1, exp_v, avs_readdata;
    logic avs_waitrequest, bridge_enable, weak_pulldown_en, short_test_gnd, short_test_supply, reset_pin_n;
    logic shutdown_n_oe, thermal_warning_low_oe, thermal_warning_high_oe, ready;
    logic [31:0] exp_q[$];
    int err_count = 0, num_checks = 0, gnd_starts = 0, n0;
    wire [31:0] pins = {26'h0, bridge_enable, shutdown_n_oe, weak_pulldown_en, ready,
        thermal_warning_low_oe, thermal_warning_high_oe};
    apsp_ctrl u_dut (.clk_sys, .rst_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .logic_supply_ok, .gate_drive_supply_ok,
        .short_gnd_det, .short_supply_det, .temp_above_100, .temp_above_125, .temp_above_155,
        .overload_det, .overcurrent_det, .reset_pin_n, .bridge_enable, .weak_pulldown_en,
        .short_test_gnd, .short_test_supply, .shutdown_n_o(), .shutdown_n_oe, .thermal_warning_low_o(),
        .thermal_warning_low_oe, .thermal_warning_high_o(), .thermal_warning_high_oe, .ready);
    // Pull-up on the open-drain shutdown pin
    apsp_host_mdl #(.GAP(GAP)) u_host (.clk_sys, .want_reset, .shutdown_n(!shutdown_n_oe), .reset_pin_n);
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge short_test_gnd) gnd_starts++;
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Request stands until the rising edge at which waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
            ok = (avs_waitrequest === 1'b0);
            n++;
        end while (!ok && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle edge so the next request never reassigns the strobe in this step
        @(posedge clk_sys);
        `CHK(ok, 1'b1)
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pin_chk(input logic [5:0] v);
        exp_q.push_back({26'h0, v});
        probe <= 1'b1;
        @(posedge clk_sys);
        probe <= 1'b0;
    endtask
    task automatic wait_on(input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (bridge_enable !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        `CHK(n < lim, 1'b1)
    endtask
    task automatic rst_pulse();
        want_reset <= 1'b1;
        cyc(4);
        want_reset <= 1'b0;
        wait_on(1'b1, GAP + 20);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // Results are taken at the rising edge, before the design updates
    always @(posedge clk_sys) begin
        if (probe || (avs_read && avs_waitrequest === 1'b0))
            exp_v = exp_q.pop_front();
        if (probe)
            `CHK(pins, exp_v)
        if (avs_read && avs_waitrequest === 1'b0)
            `CHK(avs_readdata, exp_v)
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(2);
        rd(apsp_pkg::ADDR_ID, apsp_pkg::BLOCK_ID);
        rd(apsp_pkg::ADDR_CTRL, apsp_pkg::CTRL_RESET);
        bus(1'b1, apsp_pkg::ADDR_STEP, 32'h14);
        rd(apsp_pkg::ADDR_STEP, 32'h14);
        rd(4'h2, 32'h0);
        $display("test bus done");
        // Startup with a ground short while reset is held low
        short_gnd_det <= 1'b1;
        want_reset <= 1'b1;
        logic_supply_ok <= 1'b1;
        cyc(100);
        pin_chk(6'b010000);
        short_gnd_det <= 1'b0;
        want_reset <= 1'b0;
        wait_on(1'b1, 80);
        pin_chk(6'b100100);
        n0 = gnd_starts;
        short_gnd_det <= 1'b1;
        short_supply_det <= 1'b1;
        cyc(20);
        pin_chk(6'b100100);
        want_reset <= 1'b1;
        cyc(8);
        pin_chk(6'b001000);
        short_gnd_det <= 1'b0;
        short_supply_det <= 1'b0;
        want_reset <= 1'b0;
        wait_on(1'b1, 10);
        `CHK(gnd_starts, n0)
        overcurrent_det <= 1'b1;
        cyc(6);
        pin_chk(6'b100000);
        overcurrent_det <= 1'b0;
        $display("test startup done");
        repeat (3) begin
            seed = xs(seed);
            gate_drive_supply_ok <= seed[3:0] & 4'he;
            cyc(6);
            pin_chk(6'b010000);
            gate_drive_supply_ok <= 4'hf;
            wait_on(1'b1, 10);
        end
        overload_det <= 1'b1;
        cyc(6);
        overload_det <= 1'b0;
        cyc(20);
        pin_chk(6'b010000);
        rst_pulse();
        $display("test faults done");
        for (int p = 1; p >= 0; p--) begin
            bus(1'b1, apsp_pkg::ADDR_CTRL, 32'(p) << 2);
            temp_above_100 <= 1'b1;
            cyc(5);
            pin_chk({4'b1001, p[0], 1'b0});
            temp_above_125 <= 1'b1;
            cyc(5);
            pin_chk({4'b1001, p[0], 1'b1});
            temp_above_155 <= 1'b1;
            cyc(5);
            pin_chk({4'b0100, p[0], 1'b1});
            {temp_above_100, temp_above_125, temp_above_155} <= 3'b000;
            cyc(10);
            pin_chk(6'b010000);
            rst_pulse();
        end
        $display("test thermal done");
        for (int c = 1; c < 3; c++) begin
            bus(1'b1, apsp_pkg::ADDR_CTRL, 32'(c));
            logic_supply_ok <= 1'b0;
            cyc(5);
            n0 = gnd_starts;
            logic_supply_ok <= 1'b1;
            wait_on(1'b1, 80);
            `CHK(gnd_starts - n0, int'(c < 2))
        end
        want_reset <= 1'b1;
        cyc(8);
        pin_chk(6'b000000);
        want_reset <= 1'b0;
        cyc(10);
        $display("test config done");
        close_out();
    end
endmodule

// ===== verilog/apsp_ctrl.sv
// Protection sequencer for a four half-bridge class-D power stage
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module apsp_ctrl (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog comparator inputs
    input wire logic logic_supply_ok,
    input wire logic [3:0] gate_drive_supply_ok,
    input wire logic short_gnd_det,
    input wire logic short_supply_det,
    input wire logic temp_above_100,
    input wire logic temp_above_125,
    input wire logic temp_above_155,
    input wire logic overload_det,
    input wire logic overcurrent_det,
    // Controller reset pin
    input wire logic reset_pin_n,
    // Power stage drive
    output logic bridge_enable,
    output logic weak_pulldown_en,
    output logic short_test_gnd,
    output logic short_test_supply,
    // Open-drain status pins: output forced low while enable high; ready is a plain output with no enable
    output logic shutdown_n_o,
    output logic shutdown_n_oe,
    output logic thermal_warning_low_o,
    output logic thermal_warning_low_oe,
    output logic thermal_warning_high_o,
    output logic thermal_warning_high_oe,
    output logic ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers
    // Every comparator and the reset pin are asynchronous to the oscillator.
    // Two flops cost two cycles of latency, far below any protection timing.
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] sync1_r, sync2_r, raw_in;
    assign raw_in = {reset_pin_n, overcurrent_det, overload_det, temp_above_155, temp_above_125,
                     temp_above_100, short_supply_det, short_gnd_det, gate_drive_supply_ok, logic_supply_ok};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (clk_en) begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end
    logic s_logic_ok, s_gate_ok, s_sh_gnd, s_sh_sup, s_t100, s_t125, s_t155, s_ovl, s_ocp, s_rst_n;
    assign s_logic_ok = sync2_r[0];
    assign s_gate_ok = &sync2_r[4:1];
    assign s_sh_gnd = sync2_r[5];
    assign s_sh_sup = sync2_r[6];
    assign s_t100 = sync2_r[7];
    assign s_t125 = sync2_r[8];
    assign s_t155 = sync2_r[9];
    assign s_ovl = sync2_r[10];
    assign s_ocp = sync2_r[11];
    assign s_rst_n = sync2_r[12];

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] step_r, step_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] status_word;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // One wait cycle per access; write takes effect at the edge waitrequest is low
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        step_nxt = step_r;
        rdata_nxt = rdata_r;
        ack_nxt = 1'b0;
        if ((avs_read || avs_write) && !ack_r) begin
            ack_nxt = 1'b1;
            if (avs_read) begin
                unique case (avs_address)
                    apsp_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                    apsp_pkg::ADDR_STATUS: rdata_nxt = status_word;
                    apsp_pkg::ADDR_STEP: rdata_nxt = step_r;
                    apsp_pkg::ADDR_ID: rdata_nxt = apsp_pkg::BLOCK_ID;
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
        if (avs_write && ack_r) begin
            if (avs_address == apsp_pkg::ADDR_CTRL) begin
                ctrl_nxt = be_merge(ctrl_r, avs_writedata, avs_byteenable);
            end else if (avs_address == apsp_pkg::ADDR_STEP) begin
                step_nxt = be_merge(step_r, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= apsp_pkg::CTRL_RESET;
            step_r <= 32'(apsp_pkg::SHORT_STEP_CYC);
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else if (clk_en) begin
            ctrl_r <= ctrl_nxt;
            step_r <= step_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end
    assign avs_readdata = rdata_r;

    apsp_pkg::apsp_cfg_t cfg;
    logic pkg_64pin;
    assign cfg = apsp_pkg::apsp_cfg_t'(ctrl_r[apsp_pkg::CTRL_CFG_LSB +: 2]);
    assign pkg_64pin = ctrl_r[apsp_pkg::CTRL_PKG_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Protection sequencer
    apsp_pkg::apsp_state_t st_r, st_nxt;
    logic ote_r, ote_nxt;
    logic ovl_r, ovl_nxt;
    logic rst_d_r, rst_d_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [31:0] gap_r, gap_nxt;
    logic gap_err_r, gap_err_nxt;
    logic sd_int;
    logic uv;
    logic rst_rise;
    logic gap_clr;

    // Writing one to bit CTRL_RESET_GAP_BIT (bit 3) at the STATUS address clears the early-reset flag.
    // The clear is applied before the sequencer looks at the reset edge,
    // so a set in the same cycle wins and no violation is lost.
    assign gap_clr = avs_write && ack_r && (avs_address == apsp_pkg::ADDR_STATUS) &&
                     avs_writedata[apsp_pkg::CTRL_RESET_GAP_BIT];

    // Any single supply low counts; supplies are monitored independently
    assign uv = !s_logic_ok || !s_gate_ok;
    assign rst_rise = s_rst_n && !rst_d_r;

    always_comb begin
        st_nxt = st_r;
        ote_nxt = ote_r || s_t155;
        ovl_nxt = ovl_r || s_ovl;
        rst_d_nxt = s_rst_n;
        cnt_nxt = cnt_r;
        gap_nxt = gap_r;
        // Clear first, so that a set below in this cycle overrides it
        gap_err_nxt = gap_err_r && !gap_clr;
        unique case (st_r)
            apsp_pkg::ST_POWER_OFF: begin
                ovl_nxt = 1'b0;
                ote_nxt = 1'b0;
                cnt_nxt = 32'h0000_0000;
                if (!uv) begin
                    if (cfg == apsp_pkg::CFG_SINGLE_ENDED) begin
                        st_nxt = apsp_pkg::ST_RUN;
                    end else begin
                        st_nxt = apsp_pkg::ST_CHECK_GND;
                    end
                end
            end
            apsp_pkg::ST_CHECK_GND: begin
                cnt_nxt = cnt_r + 32'h0000_0001;
                if (s_sh_gnd) begin
                    st_nxt = apsp_pkg::ST_SHORT_HOLD;
                end else if (cnt_r >= step_r) begin
                    st_nxt = apsp_pkg::ST_CHECK_SUPPLY;
                    cnt_nxt = 32'h0000_0000;
                end
            end
            apsp_pkg::ST_CHECK_SUPPLY: begin
                cnt_nxt = cnt_r + 32'h0000_0001;
                if (s_sh_sup) begin
                    st_nxt = apsp_pkg::ST_SHORT_HOLD;
                end else if (cnt_r >= step_r) begin
                    st_nxt = apsp_pkg::ST_RUN;
                end
            end
            apsp_pkg::ST_SHORT_HOLD: begin
                // Short gone: rerun from the ground step
                if (!s_sh_gnd && !s_sh_sup) begin
                    st_nxt = apsp_pkg::ST_CHECK_GND;
                    cnt_nxt = 32'h0000_0000;
                end
            end
            apsp_pkg::ST_RUN: begin
                if (!s_rst_n) begin
                    st_nxt = apsp_pkg::ST_RESET_HELD;
                end else if (ote_nxt || ovl_nxt) begin
                    st_nxt = apsp_pkg::ST_FAULT;
                end
            end
            apsp_pkg::ST_FAULT: begin
                if (!s_rst_n) begin
                    st_nxt = apsp_pkg::ST_RESET_HELD;
                end
            end
            apsp_pkg::ST_RESET_HELD: begin
                ote_nxt = 1'b0;
                ovl_nxt = 1'b0;
                if (rst_rise) begin
                    st_nxt = apsp_pkg::ST_RUN;
                    gap_err_nxt = gap_err_r || (gap_r < 32'(apsp_pkg::RESET_GAP_CYC));
                end
            end
            default: st_nxt = apsp_pkg::ST_POWER_OFF;
        endcase
        // Logic supply loss means a fresh startup later
        if (!s_logic_ok) begin
            st_nxt = apsp_pkg::ST_POWER_OFF;
        end
        // Time since shutdown fell, for the reset spacing flag
        if (sd_int) begin
            gap_nxt = 32'h0000_0000;
        end else if (gap_r != 32'hffff_ffff) begin
            gap_nxt = gap_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= apsp_pkg::ST_POWER_OFF;
            ote_r <= 1'b0;
            ovl_r <= 1'b0;
            rst_d_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            gap_r <= 32'h0000_0000;
            gap_err_r <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            ote_r <= ote_nxt;
            ovl_r <= ovl_nxt;
            rst_d_r <= rst_d_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            gap_err_r <= gap_err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic checking, fault_any, w_low, w_high;
    assign checking = (st_r == apsp_pkg::ST_CHECK_GND) || (st_r == apsp_pkg::ST_CHECK_SUPPLY) ||
                      (st_r == apsp_pkg::ST_SHORT_HOLD) || (st_r == apsp_pkg::ST_POWER_OFF);
    assign fault_any = uv || ote_r || ovl_r || (st_r == apsp_pkg::ST_FAULT);

    always_comb begin
        if (checking) begin
            sd_int = 1'b0;
        end else if (st_r == apsp_pkg::ST_RESET_HELD) begin
            sd_int = 1'b1;
        end else begin
            sd_int = !fault_any;
        end
    end

    assign bridge_enable = (st_r == apsp_pkg::ST_RUN) && !uv && !ote_r && !ovl_r && s_rst_n;
    assign weak_pulldown_en = (st_r == apsp_pkg::ST_RESET_HELD) && (cfg != apsp_pkg::CFG_SINGLE_ENDED);
    assign short_test_gnd = (st_r == apsp_pkg::ST_CHECK_GND);
    assign short_test_supply = (st_r == apsp_pkg::ST_CHECK_SUPPLY);
    assign ready = bridge_enable && !s_ocp;

    assign w_low = pkg_64pin && s_t100;
    assign w_high = s_t125;

    assign shutdown_n_o = 1'b0;
    assign shutdown_n_oe = !sd_int;
    assign thermal_warning_low_o = 1'b0;
    assign thermal_warning_low_oe = w_low;
    assign thermal_warning_high_o = 1'b0;
    assign thermal_warning_high_oe = w_high;

    // Status word layout, low bits first:
    // state code in the three lowest bits,
    // then the internal shutdown level (high = released),
    // then bridge switching,
    // then the live undervoltage condition,
    // then the latched thermal error,
    // then the latched overload,
    // then ready,
    // then the flag for a reset edge that came too soon after shutdown.
    // Upper bits read as zero.
    assign status_word = {22'h0, gap_err_r, ready, ovl_r, ote_r, uv, bridge_enable, sd_int, st_r};

endmodule

// ===== verilog/apsp_pkg.sv
// Package: constants and types for the power stage protection controller
package apsp_pkg;

    // Clock rate and timing figures
    localparam int CLK_HZ = 200_000_000;
    localparam int SHORT_STEP_MS = 15;
    localparam int SHORT_STEP_CYC = (CLK_HZ / 1000) * SHORT_STEP_MS;
    localparam int RESET_GAP_MS = 4;
    localparam int RESET_GAP_CYC = (CLK_HZ / 1000) * RESET_GAP_MS;

    // Register map (word byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_STEP = 4'h8;
    localparam logic [3:0] ADDR_ID = 4'hc;

    // Control fields
    localparam int CTRL_CFG_LSB = 0;
    localparam int CTRL_PKG_BIT = 2;
    localparam int CTRL_RESET_GAP_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Identity word: value is arbitrary
    localparam logic [31:0] BLOCK_ID = 32'h5a5a_0001;

    // Output configurations
    typedef enum logic [1:0] {
        CFG_BRIDGE_TIED = 2'b00,
        CFG_PARALLEL_BRIDGE = 2'b01,
        CFG_SINGLE_ENDED = 2'b10
    } apsp_cfg_t;

    // Protection sequencer states
    typedef enum logic [2:0] {
        ST_POWER_OFF = 3'b000,
        ST_CHECK_GND = 3'b001,
        ST_CHECK_SUPPLY = 3'b010,
        ST_SHORT_HOLD = 3'b011,
        ST_RUN = 3'b100,
        ST_FAULT = 3'b101,
        ST_RESET_HELD = 3'b110
    } apsp_state_t;

endpackage
